// ### logic/dad_pkg.sv
// Constants and types of the doubleword add and divide unit.
// Assumes one core clock and an active-low asynchronous core reset.
//
// Overview of operation
// RULE_01 - Trapping register add flags overflow if bit 62, 63 carries differ
// RULE_02 - An add that overflows does not write its destination register
// RULE_03 - Trapping imm add extends 16-bit immediate; dest is source_reg_b
// RULE_04 - Non-trapping immediate add never raises overflow
// RULE_05 - Non-trapping register add never raises overflow
// RULE_06 - Doubleword adds, divides take reserved instruction in 32-bit mode
// RULE_07 - Signed doubleword divide: 64-bit operands in two's complement
// RULE_08 - Unsigned doubleword divide: 64-bit operands as magnitudes
// RULE_09 - Every divide writes quotient_reg and remainder_reg on completion
// RULE_10 - Divides never trap; zero divisor leaves results undefined
// RULE_11 - Software gives signed word divide sign-extended 32-bit operands
// RULE_12 - Word divide sign-extends quotient and remainder from bit 31
// RULE_13 - Software puts two instructions between result reads and a divide
// RULE_14 - Opcode 011000 in bits 31..26 selects trapping immediate add
// RULE_15 - Opcode 011001 selects non-trapping immediate add with same fields
// RULE_16 - Zero opcode plus a unique function code picks adds and divides
package dad_pkg;
  localparam int DW = 64;
  localparam logic [5:0] OPC_SPECIAL  = 6'h00;
  localparam logic [5:0] OPC_ADDI_TRP = 6'h18;
  localparam logic [5:0] OPC_ADDI     = 6'h19;
  localparam logic [5:0] FN_WDIV      = 6'h1A;
  localparam logic [5:0] FN_SDIV      = 6'h1E;
  localparam logic [5:0] FN_UDIV      = 6'h1F;
  localparam logic [5:0] FN_ADD_TRP   = 6'h2C;
  localparam logic [5:0] FN_ADD       = 6'h2D;
  localparam int OPC_MSB  = 31;
  localparam int OPC_LSB  = 26;
  localparam int SRCA_LSB = 21;
  localparam int SRCB_LSB = 16;
  localparam int DEST_LSB = 11;
  localparam logic [6:0] DIV_STEPS = 7'h40;
  localparam logic [63:0] RES_RST = 64'h0000000000000000;
  typedef enum logic [2:0] {
    DAD_IDLE = 3'b001,
    DAD_RUN  = 3'b010,
    DAD_FIX  = 3'b100
  } dad_state_t;
endpackage

// ### logic/dad_divider.sv
// Sequential restoring divider, one quotient bit per clock.
// Assumes operands are held by the caller only at start.
`timescale 1ns/1ps
module dad_divider (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Request
  input  wire logic             start,
  input  wire logic [63:0]      dividend,
  input  wire logic [63:0]      divisor,
  // Result
  output logic                  done,
  output logic      [63:0]      quot,
  output logic      [63:0]      rem
);
  import dad_pkg::*;
  logic [63:0] q_reg, q_next, r_reg, r_next, d_reg, d_next;
  logic [6:0]  cnt_reg, cnt_next;
  logic        busy_reg, busy_next, done_reg, done_next;
  logic [64:0] trial;
  always_comb begin
    q_next = q_reg;
    r_next = r_reg;
    d_next = d_reg;
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    trial = {r_reg, q_reg[63]} - {1'b0, d_reg};
    if (start) begin
      q_next = dividend;
      r_next = RES_RST;
      d_next = divisor;
      cnt_next = DIV_STEPS;
      busy_next = 1'b1;
    end else if (busy_reg) begin
      if (trial[64]) begin
        r_next = {r_reg[62:0], q_reg[63]};
        q_next = {q_reg[62:0], 1'b0};
      end else begin
        r_next = trial[63:0];
        q_next = {q_reg[62:0], 1'b1};
      end
      cnt_next = cnt_reg - 7'h01;
      if (cnt_reg == 7'h01) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_reg <= RES_RST;
      r_reg <= RES_RST;
      d_reg <= RES_RST;
      cnt_reg <= 7'h00;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      q_reg <= q_next;
      r_reg <= r_next;
      d_reg <= d_next;
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end
  assign done = done_reg;
  assign quot = q_reg;
  assign rem  = r_reg;
endmodule // dad_divider

// ### logic/dad_unit.sv
// Doubleword add and divide execution unit of the integer core.
// Assumes the pipeline holds issue until ready and reads results directly.
`timescale 1ns/1ps
module dad_unit (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Issue
  input  wire logic                 issue,
  input  wire logic [31:0]          instr,
  input  wire logic                 mode64,
  input  wire logic [dad_pkg::DW-1:0] source_reg_a,
  input  wire logic [dad_pkg::DW-1:0] source_reg_b,
  output logic                      ready,
  // Register write-back
  output logic                      wb_valid,
  output logic [4:0]                wb_addr,
  output logic [dad_pkg::DW-1:0]    wb_data,
  // Exceptions
  output logic                      exc_overflow,
  output logic                      exc_reserved,
  // Divide results
  output logic                      div_done,
  output logic [dad_pkg::DW-1:0]    quotient_reg,
  output logic [dad_pkg::DW-1:0]    remainder_reg
);
  import dad_pkg::*;
  logic [5:0]  opc, fn;
  logic        is_add_trp, is_add, is_addi_trp, is_addi;
  logic        is_sdiv, is_udiv, is_wdiv, is_dw, is_div, is_addx;
  logic [63:0] imm_ext, opb, sum;
  logic        c62, c63, ovf;
  logic        wb_valid_reg, wb_valid_next, ovf_reg, ovf_next;
  logic        rsv_reg, rsv_next;
  logic [4:0]  wb_addr_reg, wb_addr_next;
  logic [63:0] wb_data_reg, wb_data_next;
  logic [63:0] quo_reg, quo_next, rmd_reg, rmd_next;
  logic        fin_reg, fin_next;
  dad_state_t  st_reg, st_next;
  logic        negq_reg, negq_next, negr_reg, negr_next;
  logic        word_reg, word_next;
  logic        dv_start;
  logic [63:0] dv_a, dv_b, dv_q, dv_r, fq, fr, fq_w, fr_w;
  logic        dv_done;
  logic [63:0] wa, wb;

  // Decode
  assign opc = instr[OPC_MSB:OPC_LSB];
  assign fn  = instr[5:0];
  // RULE_16 unique function map
  assign is_add_trp = (opc == OPC_SPECIAL) && (fn == FN_ADD_TRP);
  assign is_add     = (opc == OPC_SPECIAL) && (fn == FN_ADD);
  assign is_sdiv    = (opc == OPC_SPECIAL) && (fn == FN_SDIV);
  assign is_udiv    = (opc == OPC_SPECIAL) && (fn == FN_UDIV);
  assign is_wdiv    = (opc == OPC_SPECIAL) && (fn == FN_WDIV);
  // RULE_14 trapping immediate opcode
  assign is_addi_trp = (opc == OPC_ADDI_TRP);
  // RULE_15 plain immediate opcode
  assign is_addi     = (opc == OPC_ADDI);
  assign is_addx = is_add_trp | is_add | is_addi_trp | is_addi;
  assign is_dw   = is_addx | is_sdiv | is_udiv;
  assign is_div  = is_sdiv | is_udiv | is_wdiv;

  // RULE_03 sign-extend immediate
  assign imm_ext = {{48{instr[15]}}, instr[15:0]};
  assign opb = (is_addi_trp | is_addi) ? imm_ext : source_reg_b;
  assign sum = source_reg_a + opb;
  // RULE_01 carry compare
  assign c62 = source_reg_a[63] ^ opb[63] ^ sum[63];
  assign c63 = (source_reg_a[63] & opb[63]) |
               (c62 & (source_reg_a[63] ^ opb[63]));
  // RULE_04 RULE_05 only trapping forms
  assign ovf = (c62 != c63) & (is_add_trp | is_addi_trp);

  // Operands for word divide, sign-extended from bit 31
  assign wa = {{32{source_reg_a[31]}}, source_reg_a[31:0]};
  assign wb = {{32{source_reg_b[31]}}, source_reg_b[31:0]};
  assign ready = (st_reg == DAD_IDLE);

  always_comb begin
    dv_start = 1'b0;
    dv_a = source_reg_a;
    dv_b = source_reg_b;
    negq_next = negq_reg;
    negr_next = negr_reg;
    word_next = word_reg;
    st_next = st_reg;
    wb_valid_next = 1'b0;
    ovf_next = 1'b0;
    rsv_next = 1'b0;
    wb_addr_next = wb_addr_reg;
    wb_data_next = wb_data_reg;
    quo_next = quo_reg;
    rmd_next = rmd_reg;
    fin_next = 1'b0;
    case (st_reg)
      DAD_IDLE: begin
        if (issue) begin
          // RULE_06 reserved in 32-bit mode
          if (is_dw && !mode64) begin
            rsv_next = 1'b1;
          end else if (is_addx) begin
            // RULE_02 suppress write on overflow
            wb_valid_next = !ovf;
            ovf_next = ovf;
            wb_data_next = sum;
            wb_addr_next = (is_addi_trp | is_addi) ? instr[20:SRCB_LSB]
                                                  : instr[15:DEST_LSB];
          end else if (is_div) begin
            // RULE_10 divides raise no overflow
            dv_start = 1'b1;
            st_next = DAD_RUN;
            word_next = is_wdiv;
            if (is_udiv) begin
              // RULE_08 unsigned operands
              negq_next = 1'b0;
              negr_next = 1'b0;
            end else begin
              // RULE_07 signed magnitudes
              if (is_wdiv) begin
                dv_a = wa;
                dv_b = wb;
              end
              negq_next = dv_a[63] ^ dv_b[63];
              negr_next = dv_a[63];
              dv_a = dv_a[63] ? 64'h0 - dv_a : dv_a;
              dv_b = dv_b[63] ? 64'h0 - dv_b : dv_b;
            end
          end
        end
      end
      DAD_RUN: begin
        if (dv_done) begin
          st_next = DAD_FIX;
        end
      end
      DAD_FIX: begin
        // RULE_09 load both result registers
        quo_next = fq_w;
        rmd_next = fr_w;
        fin_next = 1'b1;
        st_next = DAD_IDLE;
      end
      default: st_next = DAD_IDLE;
    endcase
  end

  assign fq = negq_reg ? 64'h0 - dv_q : dv_q;
  assign fr = negr_reg ? 64'h0 - dv_r : dv_r;
  // RULE_12 word results sign-extended from bit 31
  assign fq_w = word_reg ? {{32{fq[31]}}, fq[31:0]} : fq;
  assign fr_w = word_reg ? {{32{fr[31]}}, fr[31:0]} : fr;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= DAD_IDLE;
      negq_reg <= 1'b0;
      negr_reg <= 1'b0;
      word_reg <= 1'b0;
      wb_valid_reg <= 1'b0;
      ovf_reg <= 1'b0;
      rsv_reg <= 1'b0;
      wb_addr_reg <= 5'h00;
      wb_data_reg <= RES_RST;
      quo_reg <= RES_RST;
      rmd_reg <= RES_RST;
      fin_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      negq_reg <= negq_next;
      negr_reg <= negr_next;
      word_reg <= word_next;
      wb_valid_reg <= wb_valid_next;
      ovf_reg <= ovf_next;
      rsv_reg <= rsv_next;
      wb_addr_reg <= wb_addr_next;
      wb_data_reg <= wb_data_next;
      quo_reg <= quo_next;
      rmd_reg <= rmd_next;
      fin_reg <= fin_next;
    end
  end

  dad_divider u_div (
    .clk      (clk),
    .rst_n    (rst_n),
    .start    (dv_start),
    .dividend (dv_a),
    .divisor  (dv_b),
    .done     (dv_done),
    .quot     (dv_q),
    .rem      (dv_r)
  );

  assign wb_valid      = wb_valid_reg;
  assign wb_addr       = wb_addr_reg;
  assign wb_data       = wb_data_reg;
  assign exc_overflow  = ovf_reg;
  assign exc_reserved  = rsv_reg;
  assign div_done      = fin_reg;
  assign quotient_reg  = quo_reg;
  assign remainder_reg = rmd_reg;

  // Assertions
  a_ovf_no_write: assert property (@(posedge clk) // RULE_02
    disable iff (!rst_n) exc_overflow |-> !wb_valid)
    else $error("write with overflow");
  a_ovf_trap_only: assert property (@(posedge clk) // RULE_04
    disable iff (!rst_n)
    (issue && ready && mode64 && (is_add || is_addi)) |=> !exc_overflow)
    else $error("plain add trapped");
  a_add_no_trap: assert property (@(posedge clk) // RULE_05
    disable iff (!rst_n) (issue && ready && is_add) |=> !exc_overflow)
    else $error("register add trapped");
  a_ovf_carry: assert property (@(posedge clk) // RULE_01
    disable iff (!rst_n)
    (issue && ready && mode64 && is_add_trp) |=> exc_overflow ==
    ($past(source_reg_a[63]) == $past(source_reg_b[63]) &&
     $past(sum[63]) != $past(source_reg_a[63])))
    else $error("overflow mismatch");
  a_rsv_mode: assert property (@(posedge clk) // RULE_06
    disable iff (!rst_n)
    (issue && ready && !mode64 && is_dw) |=> exc_reserved && !wb_valid)
    else $error("no reserved exception");
  a_div_notrap: assert property (@(posedge clk) // RULE_10
    disable iff (!rst_n) !ready |-> !exc_overflow)
    else $error("divide trapped");
  a_div_finish: assert property (@(posedge clk) // RULE_09
    disable iff (!rst_n)
    (issue && ready && mode64 && is_div) |-> ##[66:68] div_done)
    else $error("divide late");
  a_word_sext: assert property (@(posedge clk) // RULE_12
    disable iff (!rst_n)
    (div_done && $past(word_reg)) |->
    (quotient_reg[63:32] == {32{quotient_reg[31]}}) &&
    (remainder_reg[63:32] == {32{remainder_reg[31]}}))
    else $error("word not extended");
  a_imm_dest: assert property (@(posedge clk) // RULE_03
    disable iff (!rst_n)
    (issue && ready && mode64 && (is_addi_trp || is_addi) && !ovf) |=>
    wb_valid && wb_addr == $past(instr[20:16]))
    else $error("immediate dest wrong");
  c_add: cover property (@(posedge clk) issue && ready && is_add);
  c_ovf: cover property (@(posedge clk) exc_overflow);
  c_div: cover property (@(posedge clk) div_done);
  c_rsv: cover property (@(posedge clk) exc_reserved);
endmodule // dad_unit

// ### verif/dad_gpr_model.sv
// Register file model that sits behind the unit's write-back port.
// Assumes write-back pulses are sampled on the rising core clock.
`timescale 1ns/1ps
module dad_gpr_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Write-back from the unit
  input  wire logic        wb_valid,
  input  wire logic [4:0]  wb_addr,
  input  wire logic [63:0] wb_data,
  // Bench read side
  input  wire logic [4:0]  rd_addr,
  output logic      [63:0] rd_data,
  output logic      [7:0]  wr_count
);
  logic [63:0] mem [32];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_count <= 8'h00;
    end else if (wb_valid) begin
      mem[wb_addr] <= wb_data;
      wr_count     <= wr_count + 8'h01;
    end
  end

  assign rd_data = mem[rd_addr];
endmodule // dad_gpr_model

// ### verif/testbench.sv
// Self-checking bench of the doubleword add and divide unit.
// Assumes a 50 MHz core clock and the register file model.
`timescale 1ns/1ps
module testbench;
  import dad_pkg::*;
  logic clk, rst_n, issue, mode64, ready, wb_valid, exc_overflow;
  logic exc_reserved, div_done;
  logic [31:0] instr;
  logic [63:0] src_a, src_b, wb_data, quot, rem, rd_data;
  logic [4:0]  wb_addr, rd_addr;
  logic [7:0]  wr_count;
  logic        s_wb, s_ovf, s_res, s_div;
  logic [63:0] c_data;
  int errors, num_checks, cycles, n_busy;

  dad_unit i_dut (.clk(clk), .rst_n(rst_n), .issue(issue), .instr(instr),
    .mode64(mode64), .source_reg_a(src_a), .source_reg_b(src_b),
    .ready(ready), .wb_valid(wb_valid), .wb_addr(wb_addr),
    .wb_data(wb_data), .exc_overflow(exc_overflow),
    .exc_reserved(exc_reserved), .div_done(div_done),
    .quotient_reg(quot), .remainder_reg(rem));
  dad_gpr_model i_gpr (.clk(clk), .rst_n(rst_n), .wb_valid(wb_valid),
    .wb_addr(wb_addr), .wb_data(wb_data), .rd_addr(rd_addr),
    .rd_data(rd_data), .wr_count(wr_count));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic end_sim();
    $display("errors=%0d checks=%0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      end_sim();
    end
  end

  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  // Issue one instruction and collect every answer for 75 cycles
  task automatic run(input logic [31:0] ins, input logic [63:0] a, b,
                     input logic m64);
    {s_wb, s_ovf, s_res, s_div} = 4'h0;
    n_busy = 0;
    c_data = 64'h0;
    issue <= 1'b1; instr <= ins; src_a <= a; src_b <= b; mode64 <= m64;
    @(posedge clk);
    issue <= 1'b0;
    for (int i = 0; i < 75; i++) begin
      #1;
      if (wb_valid === 1'b1) begin
        s_wb = 1'b1;
        c_data = wb_data;
      end
      s_ovf |= (exc_overflow === 1'b1);
      s_res |= (exc_reserved === 1'b1);
      s_div |= (div_done === 1'b1);
      n_busy += (ready === 1'b0);
      @(posedge clk);
    end
  endtask

  function automatic logic [31:0] reg_op(input logic [5:0] fn);
    return {OPC_SPECIAL, 5'h01, 5'h02, 5'h03, 5'h00, fn};
  endfunction

  // Idle output state expected after reset
  function automatic logic idle_ok();
    return ready === 1'b1 && wb_valid === 1'b0 && exc_overflow === 1'b0
      && exc_reserved === 1'b0 && div_done === 1'b0 && quot === RES_RST
      && rem === RES_RST && wb_data === RES_RST && wb_addr === 5'h00;
  endfunction

  // Reset state, refusal while dividing, reset in mid-divide
  task automatic t_reset();
    #1;
    chk(idle_ok(), "state after reset");
    @(posedge clk);
    issue <= 1'b1;
    instr <= reg_op(FN_UDIV);
    src_a <= 64'h64;
    src_b <= 64'h7;
    @(posedge clk);
    instr <= reg_op(FN_ADD);
    @(posedge clk);
    issue <= 1'b0;
    s_wb = 1'b0;
    n_busy = 0;
    for (int i = 0; i < 8; i++) begin
      #1;
      s_wb |= (wb_valid === 1'b1);
      n_busy += (ready === 1'b0);
      @(posedge clk);
    end
    chk(!s_wb && n_busy == 8, "issue taken while dividing");
    rst_n <= 1'b0;
    #1;
    chk(idle_ok(), "state in mid-run reset");
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    run(reg_op(FN_ADD), 64'h1, 64'h2, 1'b1);
    chk(s_wb && c_data === 64'h3 && !s_div, "add after reset");
  endtask

  task automatic t_add_reg();
    logic [7:0] n;
    n = wr_count;
    run(reg_op(FN_ADD_TRP), 64'h7FFFFFFFFFFFFFFF, 64'h1, 1'b1);
    chk(s_ovf && !s_wb, "trap add overflow");
    chk(wr_count === n, "write on overflow");
    run(reg_op(FN_ADD_TRP), 64'h5, 64'hFFFFFFFFFFFFFFFD, 1'b1);
    rd_addr <= 5'h03;
    #1;
    chk(!s_ovf && rd_data === 64'h2, "trap add sum");
    run(reg_op(FN_ADD), 64'h7FFFFFFFFFFFFFFF, 64'h1, 1'b1);
    chk(!s_ovf && c_data === 64'h8000000000000000, "plain add");
    chk(s_wb && n_busy == 0, "plain add write");
    run(reg_op(6'h2E), 64'h4, 64'h2, 1'b1);
    chk(!s_wb && !s_ovf && !s_res && !s_div, "function map");
  endtask

  task automatic t_add_imm();
    run({OPC_ADDI_TRP, 5'h01, 5'h07, 16'h0001}, 64'h7FFFFFFFFFFFFFFF,
        64'h0, 1'b1);
    chk(s_ovf && !s_wb, "imm trap overflow");
    run({OPC_ADDI_TRP, 5'h01, 5'h07, 16'hFFFF}, 64'hA, 64'h0, 1'b1);
    chk(!s_ovf && c_data === 64'h9 && wb_addr === 5'h07, "imm sum");
    run({OPC_ADDI, 5'h01, 5'h09, 16'h0001}, 64'h7FFFFFFFFFFFFFFF,
        64'h0, 1'b1);
    chk(!s_ovf && wb_addr === 5'h09, "imm no trap");
    chk(c_data === 64'h8000000000000000, "imm plain sum");
  endtask

  task automatic t_mode32();
    logic [5:0] fns [4] = '{FN_ADD_TRP, FN_ADD, FN_SDIV, FN_UDIV};
    foreach (fns[i]) begin
      run(reg_op(fns[i]), 64'h4, 64'h2, 1'b0);
      chk(s_res && !s_wb && !s_div && n_busy == 0, "32-bit reserved");
    end
    run({OPC_ADDI, 5'h01, 5'h09, 16'h0001}, 64'h4, 64'h0, 1'b0);
    chk(s_res && !s_wb, "32-bit imm reserved");
  endtask

  task automatic t_div();
    run(reg_op(FN_SDIV), 64'hFFFFFFFFFFFFFFF9, 64'h2, 1'b1);
    chk(s_div && quot === 64'hFFFFFFFFFFFFFFFD, "sdiv quot");
    chk(rem === 64'hFFFFFFFFFFFFFFFF && !s_ovf, "sdiv rem");
    chk(n_busy == int'(DIV_STEPS) + 2, "divide busy time");
    run(reg_op(FN_UDIV), 64'hFFFFFFFFFFFFFFF9, 64'h10, 1'b1);
    chk(quot === 64'h0FFFFFFFFFFFFFFF && rem === 64'h9, "udiv");
    run(reg_op(FN_WDIV), 64'hFFFFFFFFFFFFFF9C, 64'h7, 1'b0);
    chk(quot === 64'hFFFFFFFFFFFFFFF2, "wdiv quot");
    chk(rem === 64'hFFFFFFFFFFFFFFFE && !s_res, "wdiv rem");
    run(reg_op(FN_WDIV), 64'h64, 64'hFFFFFFFFFFFFFFF9, 1'b1);
    chk(s_div && quot === 64'hFFFFFFFFFFFFFFF2, "wdiv neg divisor");
    chk(rem === 64'h2 && !s_res, "wdiv 64-bit rem");
    run(reg_op(FN_SDIV), 64'h1234, 64'h0, 1'b1);
    chk(s_div && !s_ovf && !s_res, "zero divisor");
  endtask

  initial begin
    rst_n = 1'b0; issue = 1'b0; instr = 32'h0; mode64 = 1'b1;
    src_a = 64'h0; src_b = 64'h0; rd_addr = 5'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_add_reg();
    t_add_imm();
    t_mode32();
    // bench reads results in the cycle before it issues the next divide
    t_div();
    end_sim();
  end
endmodule // testbench
